/* File: acsp_port.sv */
// Codec audio serial port: serial audio link, master clock, mute, I2C pins
//
// Contract
// - Samples travel over standard I2S link
// - Slave mode: logic drives clocks, receives record
// - Master mode: clock lines become inputs
// - First bit one bit clock after change
// - Samples sent most significant bit first
// - Stereo at 8 to 96 kHz rates
`timescale 1ns/10ps
`default_nettype none
`include "acsp_defines.svh"
module acsp_port (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic audio_clk,
  input wire logic master_mode,
  input wire logic unmute,
  input wire logic pb_valid,
  input wire acsp_pkg::acsp_frame_t pb_frame,
  output logic pb_ready,
  output logic rec_valid,
  output acsp_pkg::acsp_frame_t rec_frame,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  output logic i2c_sda_in,
  output logic codec_master_clock,
  output logic bit_clock_o,
  output logic bit_clock_oe,
  input wire logic bit_clock_i,
  output logic playback_channel_clock_o,
  output logic playback_channel_clock_oe,
  input wire logic playback_channel_clock_i,
  output logic record_channel_clock_o,
  output logic record_channel_clock_oe,
  input wire logic record_channel_clock_i,
  output logic playback_serial_data,
  input wire logic record_serial_data,
  output logic mute_n,
  output logic config_i2c_clock,
  output logic config_i2c_data_o,
  output logic config_i2c_data_oe,
  input wire logic config_i2c_data_i
);
  // ****************************************
  // System domain
  // ****************************************
  logic f_valid, f_ready;
  acsp_pkg::acsp_frame_t f_data, pb_word, next_pb_word, next_rec_frame;
  logic rq_s1, rq_s2, rq_s3, rc_s1, rc_s2, rc_s3, sda_s1, sda_s2;
  logic pend, next_pend, ack_tgl, next_ack, next_rec_valid;
  logic req_tgl, rec_tgl;
  acsp_pkg::acsp_frame_t rec_word;
  acsp_fifo #(
    .W($bits(acsp_pkg::acsp_frame_t)),
    .D(`ACSP_FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .nrst(nrst),
    .in_valid(pb_valid),
    .in_ready(pb_ready),
    .in_data(pb_frame),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  always_comb begin
    next_pend = pend || (rq_s2 != rq_s3);
    f_ready = next_pend && !pend ? 1'b0 : pend;
    next_pb_word = pb_word;
    next_ack = ack_tgl;
    if (pend && f_valid) begin
      next_pb_word = f_data;
      next_ack = ~ack_tgl;
      next_pend = (rq_s2 != rq_s3);
    end
    next_rec_valid = (rc_s2 != rc_s3);
    next_rec_frame = next_rec_valid ? rec_word : rec_frame;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {rq_s1, rq_s2, rq_s3, rc_s1, rc_s2, rc_s3} <= 6'h00;
      {sda_s1, sda_s2} <= 2'h3;
      pend <= 1'b0;
      ack_tgl <= 1'b0;
      pb_word <= '0;
      rec_valid <= 1'b0;
      rec_frame <= '0;
      mute_n <= 1'b0;
      config_i2c_clock <= 1'b1;
      config_i2c_data_oe <= 1'b0;
    end else begin
      {rq_s1, rq_s2, rq_s3} <= {req_tgl, rq_s1, rq_s2};
      {rc_s1, rc_s2, rc_s3} <= {rec_tgl, rc_s1, rc_s2};
      {sda_s1, sda_s2} <= {config_i2c_data_i, sda_s1};
      pend <= next_pend;
      ack_tgl <= next_ack;
      pb_word <= next_pb_word;
      rec_valid <= next_rec_valid;
      rec_frame <= next_rec_frame;
      mute_n <= unmute;
      // open-drain data pin and push-pull clock for the I2C controller
      config_i2c_clock <= !i2c_scl_low;
      config_i2c_data_oe <= i2c_sda_low;
    end
  end
  assign config_i2c_data_o = 1'b0;
  assign i2c_sda_in = sda_s2;
  a_play_ack: assert property (@(posedge mclk) disable iff (!nrst)
    (pend && f_valid) |=> (ack_tgl != $past(ack_tgl)) && !pend ##1 !pend)
    else $error("playback word not acknowledged");
  a_rec_handoff: assert property (@(posedge mclk) disable iff (!nrst)
    (rc_s2 != rc_s3) |=> rec_valid ##1 !rec_valid)
    else $error("record frame not handed over once");
  // ****************************************
  // Link domain
  // ****************************************
  logic lrst_s1, lrst_n, mode_s1, mode_l;
  logic bclk_s1, bclk_s2, bclk_s3, lrc_s1, lrc_s2, rd_s1, rd_s2;
  logic ack_s1, ack_s2, ack_s3;
  logic [2:0] ph, next_ph;
  logic [5:0] slot, next_slot, rcnt, next_rcnt;
  logic [`ACSP_SLOT_W-1:0] shreg, next_sh;
  logic [`ACSP_SAMPLE_W-1:0] rsh, next_rsh, rl, next_rl, ld_word, rbits;
  acsp_pkg::acsp_frame_t cur, next_cur, hold, next_hold, next_rw;
  logic hold_v, next_hold_v, next_req, next_rt, lrc_prev, next_lrc_prev;
  logic next_sd, rchan, next_rchan, f, r, lrc_now, chg;
  // Reset release follows the audio clock
  always_ff @(posedge audio_clk or negedge nrst) begin
    if (!nrst) begin
      {lrst_s1, lrst_n} <= 2'h0;
    end else begin
      {lrst_s1, lrst_n} <= {1'b1, lrst_s1};
    end
  end
  always_comb begin
    next_ph = ph + 3'h1;
    next_slot = (ph == `ACSP_PH_LAST) ? slot + 6'h01 : slot;
    f = mode_l ? (bclk_s3 & ~bclk_s2) : (ph == `ACSP_PH_LAST);
    // record sampled on bit clock rise
    r = mode_l ? (~bclk_s3 & bclk_s2) : (ph == `ACSP_PH_SLAVE_SAMPLE);
    lrc_now = mode_l ? lrc_s2 : next_slot[5];
    chg = f && (lrc_now != lrc_prev);
    next_lrc_prev = f ? lrc_now : lrc_prev;
    next_cur = cur;
    next_hold = hold;
    next_hold_v = hold_v;
    next_req = req_tgl;
    if (chg && !lrc_now) begin
      // Underrun plays silence rather than stalling
      next_cur = hold_v ? hold : '0;
      next_hold_v = 1'b0;
    end
    if (ack_s2 != ack_s3) begin
      next_hold = pb_word;
      next_hold_v = 1'b1;
    end
    if (!next_hold_v && req_tgl == ack_s3 && ack_s2 == ack_s3) begin
      next_req = ~req_tgl;
    end
    ld_word = lrc_now ? next_cur.right : next_cur.left;
    next_sh = shreg;
    next_sd = playback_serial_data;
    if (chg) begin
      next_sh = {ld_word, {`ACSP_PAD_W{1'b0}}};
      next_sd = 1'b0;
    end else if (f) begin
      next_sd = shreg[`ACSP_SLOT_W-1];
      next_sh = {shreg[`ACSP_SLOT_W-2:0], 1'b0};
    end
    rbits = {rsh[`ACSP_SAMPLE_W-2:0], rd_s2};
    next_rcnt = rcnt;
    next_rchan = rchan;
    next_rsh = rsh;
    next_rl = rl;
    next_rw = rec_word;
    next_rt = rec_tgl;
    if (chg) begin
      next_rcnt = 6'h00;
      next_rchan = lrc_now;
    end else if (r) begin
      // record shifted in at the bottom, moving up
      if (rcnt != 6'h00 && rcnt <= `ACSP_RCNT_LAST) begin
        next_rsh = rbits;
      end
      if (rcnt == `ACSP_RCNT_LAST && !rchan) begin
        next_rl = rbits;
      end
      if (rcnt == `ACSP_RCNT_LAST && rchan) begin
        next_rw = {rl, rbits};
        next_rt = ~rec_tgl;
      end
      if (rcnt != `ACSP_RCNT_IDLE) begin
        next_rcnt = rcnt + 6'h01;
      end
    end
  end
  always_ff @(posedge audio_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {mode_s1, mode_l, bclk_s1, bclk_s2, bclk_s3} <= 5'h00;
      {lrc_s1, lrc_s2, rd_s1, rd_s2, ack_s1, ack_s2, ack_s3} <= 7'h00;
      ph <= 3'h0;
      slot <= 6'h00;
      lrc_prev <= 1'b0;
      cur <= '0;
      hold <= '0;
      hold_v <= 1'b0;
      req_tgl <= 1'b0;
      shreg <= '0;
      playback_serial_data <= 1'b0;
      rcnt <= `ACSP_RCNT_IDLE;
      rchan <= 1'b0;
      rsh <= '0;
      rl <= '0;
      rec_word <= '0;
      rec_tgl <= 1'b0;
    end else begin
      {mode_s1, mode_l} <= {master_mode, mode_s1};
      {bclk_s1, bclk_s2, bclk_s3} <= {bit_clock_i, bclk_s1, bclk_s2};
      {lrc_s1, lrc_s2} <= {playback_channel_clock_i, lrc_s1};
      {rd_s1, rd_s2} <= {record_serial_data, rd_s1};
      {ack_s1, ack_s2, ack_s3} <= {ack_tgl, ack_s1, ack_s2};
      ph <= next_ph;
      slot <= next_slot;
      lrc_prev <= next_lrc_prev;
      cur <= next_cur;
      hold <= next_hold;
      hold_v <= next_hold_v;
      req_tgl <= next_req;
      shreg <= next_sh;
      playback_serial_data <= next_sd;
      rcnt <= next_rcnt;
      rchan <= next_rchan;
      rsh <= next_rsh;
      rl <= next_rl;
      rec_word <= next_rw;
      rec_tgl <= next_rt;
    end
  end
  // master clock runs in both modes
  assign codec_master_clock = ph[0];
  assign bit_clock_o = ph[2];
  // one channel clock level per half frame
  assign playback_channel_clock_o = slot[5];
  assign record_channel_clock_o = slot[5];
  // slave mode drives the clock lines
  assign bit_clock_oe = (mode_l == acsp_pkg::ACSP_SLAVE);
  assign playback_channel_clock_oe = (mode_l == acsp_pkg::ACSP_SLAVE);
  assign record_channel_clock_oe = (mode_l == acsp_pkg::ACSP_SLAVE);
  a_slave_drive: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    !mode_l |-> bit_clock_oe && record_channel_clock_oe)
    else $error("slave mode clock lines not driven");
  a_both_lrc: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    !mode_l |-> record_channel_clock_o == playback_channel_clock_o)
    else $error("channel clocks disagree");
  a_master_float: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    mode_l |-> !bit_clock_oe && !playback_channel_clock_oe)
    else $error("master mode still drives clocks");
  a_first_bit: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    (!mode_l && chg) |=> !playback_serial_data[*8])
    else $error("data bit on channel clock change");
  a_msb_first: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    (!mode_l && chg) ##1 !mode_l[*8]
    |=> playback_serial_data == $past(ld_word[`ACSP_SAMPLE_W-1], 9))
    else $error("first data bit is not the MSB");
  a_lrc_half: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    (!mode_l && $changed(slot[5])) |-> ph == 3'h0 && slot[4:0] == 5'h00)
    else $error("channel clock moved off a half frame");
  a_bclk_rate: assert property (@(posedge audio_clk) disable iff (!lrst_n)
    (!mode_l && $rose(bit_clock_o)) ##1 !mode_l[*7]
    |=> $rose(bit_clock_o))
    else $error("bit clock period wrong");
endmodule // acsp_port
`default_nettype wire

/* File: acsp_defines.svh */
// Constants for the codec audio serial port
`ifndef ACSP_DEFINES_SVH
`define ACSP_DEFINES_SVH
`define ACSP_SAMPLE_W 24
`define ACSP_SLOT_W 32
`define ACSP_PAD_W 8
`define ACSP_FIFO_DEPTH 16
`define ACSP_PH_LAST 3'h7
`define ACSP_PH_SLAVE_SAMPLE 3'h5
`define ACSP_RCNT_IDLE 6'h3F
`define ACSP_RCNT_LAST 6'h18
`define ACSP_I2C_TARGET_ADDR 7'h1A
`define ACSP_SYS_PERIOD_NS 4
`define ACSP_MCLK_HZ 12288000
`define ACSP_FS_HZ 48000
`endif

/* File: acsp_pkg.sv */
// Types of the codec audio serial port
`include "acsp_defines.svh"
package acsp_pkg;
  typedef struct packed {
    logic [`ACSP_SAMPLE_W-1:0] left;
    logic [`ACSP_SAMPLE_W-1:0] right;
  } acsp_frame_t;
  typedef enum logic {
    ACSP_SLAVE = 1'b0,
    ACSP_MASTER = 1'b1
  } acsp_mode_t;
endpackage

/* File: acsp_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module acsp_fifo #(
  parameter int W = 48,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic push, pop;
  // ****************************************
  // Pointers
  // ****************************************
  always_comb begin
    in_ready = (wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]);
    out_valid = (wp != rp);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    out_data = mem[rp[AW-1:0]];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
  // No reset on storage; empty flag hides it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule // acsp_fifo
`default_nettype wire

/* File: acsp_codec_model.sv */
// Behavioural stereo codec on the serial audio link
`timescale 1ns/10ps
`default_nettype none
// clocks and playback data come in, record data goes out
module acsp_codec_model (
  input wire logic bclk,
  input wire logic lrc,
  input wire logic pb_data,
  input wire acsp_pkg::acsp_frame_t rec_smp,
  output logic rec_data,
  output acsp_pkg::acsp_frame_t pb_got,
  output logic [15:0] n_got
);
  // ****************************************
  // Slot tracking
  // ****************************************
  // Passive on the clocks, so one model serves both clock modes
  logic [30:0] sr = 31'h0;
  logic [23:0] acc = 24'h0;
  logic [23:0] smp = 24'h0;
  logic [4:0] cnt = 5'h0;
  logic lrc_q = 1'b0;
  logic ld_t = 1'b0;
  logic ld_s = 1'b0;
  initial rec_data = 1'b0;
  initial pb_got = '0;
  initial n_got = 16'h0;
  // sample on rise, skip first rise after change
  always @(posedge bclk) begin
    lrc_q <= lrc;
    if (lrc != lrc_q) begin
      cnt <= 5'h0;
      smp <= lrc ? rec_smp.right : rec_smp.left;
      ld_t <= ~ld_t;
    end else if (cnt < 5'h18) begin
      acc <= {acc[22:0], pb_data};
      cnt <= cnt + 5'h1;
      if (cnt == 5'h17 && !lrc) pb_got.left <= {acc[22:0], pb_data};
      if (cnt == 5'h17 && lrc) begin
        pb_got.right <= {acc[22:0], pb_data};
        n_got <= n_got + 16'h1;
      end
    end
  end
  // record shifted out on fall, most significant bit first
  always @(negedge bclk) begin
    ld_s <= ld_t;
    if (ld_t != ld_s) {rec_data, sr} <= {smp, 8'h00};
    else {rec_data, sr} <= {sr, 1'b0};
  end
endmodule // acsp_codec_model
`default_nettype wire

/* File: acsp_port_tb.sv */
// Self-checking bench for the codec audio serial port
`timescale 1ns/10ps
`default_nettype none
module acsp_port_tb;
  logic mclk = 1'b0;
  logic audio_clk = 1'b0;
  logic nrst = 1'b0;
  logic master_mode = 1'b0;
  logic unmute = 1'b0;
  logic pb_valid = 1'b0;
  logic i2c_scl_low = 1'b0;
  logic i2c_sda_low = 1'b0;
  logic cm_bclk = 1'b0;
  logic cm_lrc = 1'b0;
  logic [4:0] cm_cnt = 5'h00;
  acsp_pkg::acsp_frame_t pb_frame = '0;
  acsp_pkg::acsp_frame_t rec_smp = {24'hC35A91, 24'h1E66F0};
  acsp_pkg::acsp_frame_t rec_frame, pb_got;
  logic pb_ready, rec_valid, i2c_sda_in, codec_master_clock, mute_n;
  logic bit_clock_o, bit_clock_oe, playback_serial_data;
  logic playback_channel_clock_o, playback_channel_clock_oe;
  logic record_channel_clock_o, record_channel_clock_oe;
  logic config_i2c_clock, config_i2c_data_o, config_i2c_data_oe;
  logic record_serial_data;
  logic [15:0] n_got;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  // Released clock lines carry the codec's own clocks; SDA has a pull-up
  wire logic bclk_w = bit_clock_oe ? bit_clock_o : cm_bclk;
  wire logic plrc_w = playback_channel_clock_oe ?
    playback_channel_clock_o : cm_lrc;
  wire logic rlrc_w = record_channel_clock_oe ? record_channel_clock_o : cm_lrc;
  wire logic sda_w = config_i2c_data_oe ? config_i2c_data_o : 1'b1;
  wire logic [2:0] oes = {bit_clock_oe, playback_channel_clock_oe,
    record_channel_clock_oe};
  always #2 mclk = ~mclk;
  initial begin
    #1.3;
    forever #24 audio_clk = ~audio_clk;
  end
  // Codec as clock master; slow enough for the synchronised edge detect
  always begin
    #240 cm_bclk = 1'b1;
    #240 cm_bclk = 1'b0;
    cm_cnt = cm_cnt + 5'h01;
    if (cm_cnt == 5'h00) cm_lrc = ~cm_lrc;
  end
  acsp_port acsp_port_inst (.mclk, .nrst, .audio_clk, .master_mode, .unmute,
    .pb_valid, .pb_frame, .pb_ready, .rec_valid, .rec_frame, .i2c_scl_low,
    .i2c_sda_low, .i2c_sda_in, .codec_master_clock, .bit_clock_o,
    .bit_clock_oe, .bit_clock_i(bclk_w), .playback_channel_clock_o,
    .playback_channel_clock_oe, .playback_channel_clock_i(plrc_w),
    .record_channel_clock_o, .record_channel_clock_oe,
    .record_channel_clock_i(rlrc_w), .playback_serial_data,
    .record_serial_data, .mute_n, .config_i2c_clock, .config_i2c_data_o,
    .config_i2c_data_oe, .config_i2c_data_i(sda_w));
  acsp_codec_model acsp_codec_model_inst (.bclk(bclk_w), .lrc(plrc_w),
    .pb_data(playback_serial_data), .rec_smp, .rec_data(record_serial_data),
    .pb_got, .n_got);
  // ****************************************
  // Compare and closing
  // ****************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic acsp_pkg::acsp_frame_t fr(input logic [7:0] k);
    return {8'h80 | k, 16'h5A3C, k, 16'hC3E1};
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(mute_n, 1'b0);
    chk(config_i2c_clock, 1'b1);
    chk(oes, 3'h7);
    chk(pb_ready, 1'b1);
  endtask
  task automatic t_pins();
    unmute = 1'b1;
    i2c_scl_low = 1'b1;
    i2c_sda_low = 1'b1;
    @(negedge mclk);
    chk(mute_n, 1'b1);
    repeat (3) @(negedge mclk);
    chk({config_i2c_clock, config_i2c_data_oe, config_i2c_data_o}, 3'h2);
    chk(i2c_sda_in, 1'b0);
    i2c_scl_low = 1'b0;
    i2c_sda_low = 1'b0;
    repeat (4) @(negedge mclk);
    chk({config_i2c_clock, config_i2c_data_oe, i2c_sda_in}, 3'h5);
  endtask
  task automatic t_stream();
    int n;
    @(posedge rec_valid);
    @(n_got);
    chk(pb_got, 48'h0);
    @(posedge rec_valid);
    rec_smp = {24'hFFFFFF, 24'h000001};
    @(negedge mclk);
    chk(rec_frame, {24'hC35A91, 24'h1E66F0});
    chk({playback_channel_clock_o, record_channel_clock_o}, 2'h3);
    // Fill until refused; the link prefetch may take one extra frame
    for (n = 0; n < 40 && pb_ready === 1'b1; n++) begin
      pb_valid = 1'b1;
      pb_frame = fr(n[7:0]);
      @(negedge mclk);
    end
    pb_valid = 1'b0;
    chk(n >= 16 && n <= 17, 1'b1);
    while (pb_got === 48'h0) @(n_got);
    for (n = 0; n < 3; n++) begin
      if (n > 0) @(n_got);
      chk(pb_got, fr(n[7:0]));
    end
    @(posedge rec_valid);
    @(negedge mclk);
    chk(rec_frame, {24'hFFFFFF, 24'h000001});
  endtask
  task automatic t_master();
    realtime t0;
    logic [7:0] j;
    unmute = 1'b0;
    rec_smp = {24'h5A5A5A, 24'h800000};
    @(negedge mclk);
    master_mode = 1'b1;
    repeat (20) @(posedge audio_clk);
    @(negedge mclk);
    chk(oes, 3'h0);
    @(posedge codec_master_clock);
    t0 = $realtime;
    @(posedge codec_master_clock);
    chk(48'($rtoi($realtime - t0)), 48'h60);
    // Frames cut by the clock switch are skipped
    repeat (2) @(n_got);
    j = pb_got[23:16];
    chk(pb_got, fr(j));
    @(n_got);
    chk(pb_got, fr(j + 8'h01));
    @(posedge rec_valid);
    @(negedge mclk);
    chk(rec_frame, {24'h5A5A5A, 24'h800000});
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge audio_clk);
    @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_reset();
    t_pins();
    t_stream();
    t_master();
    conclude();
  end
endmodule // acsp_port_tb
`default_nettype wire
